//--- common/acx_defines.vh
// Purpose: shared constants of the converter output control block
// Assumes: byte addresses on the register bus, 32-bit data words
// Notes: definitions only
`ifndef ACX_DEFINES_VH
`define ACX_DEFINES_VH

`define ACX_SAMPLE_W 12
`define ACX_ADDR_W 5

// register byte offsets
`define ACX_OFF_CTRL 5'h00
`define ACX_OFF_STATUS 5'h04
`define ACX_OFF_IRQ_STATUS 5'h08
`define ACX_OFF_IRQ_MASK 5'h0C
`define ACX_OFF_SAMPLE_COUNT 5'h10

// control register fields
`define ACX_CTRL_MODE_LSB 0
`define ACX_CTRL_MODE_MSB 2
`define ACX_CTRL_AC_INV_BIT 3
`define ACX_CTRL_RESET 32'h0000_0005

// clock input modes
`define ACX_MODE_DIFF 3'h1
`define ACX_MODE_TRUE_SE 3'h2
`define ACX_MODE_INV_SE 3'h3
`define ACX_MODE_AC 3'h4
`define ACX_MODE_TTL 3'h5

// status register fields
`define ACX_ST_WORD_LSB 0
`define ACX_ST_INRANGE_BIT 12
`define ACX_ST_CE_LOW_BIT 13
`define ACX_ST_FMT_BIT 14
`define ACX_ST_HOLD_BIT 15
`define ACX_ST_SEL_LSB 16

// interrupt bits
`define ACX_IRQ_W 3
`define ACX_IRQ_SAMPLE 0
`define ACX_IRQ_UNDER 1
`define ACX_IRQ_OVER 2
`define ACX_IRQ_MASK_RESET 3'h0

// output codes
`define ACX_CODE_LOW 12'h000
`define ACX_CODE_HIGH 12'hFFF
`define ACX_STROBE_ON 2'h1

`endif

//--- logic/acx_pin_sync.v
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: each bit is an independent level from outside the core clock
// Notes: the first stage is read only by the second stage
`timescale 1ns/10ps
module acx_pin_sync #(
   parameter WIDTH = 1
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);
   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= {WIDTH{1'b0}};
         sync_r <= {WIDTH{1'b0}};
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;
endmodule

//--- logic/acx_format_ctrl.v
// Purpose: digital output side of a 12-bit sampling converter with register access
// Assumes: the converter core holds its code and range flags stable around each sampling edge
// Notes: all converter-side input pins pass two flip-flops, the bus pins do not; outputs come straight from flip-flops
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "acx_defines.vh"
module acx_format_ctrl #(
   parameter SAMPLE_W = `ACX_SAMPLE_W
) (
   input wire CORE_CLK_I,
   input wire RST_N_I,
   input wire [`ACX_ADDR_W-1:0] AVS_ADDRESS_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire [31:0] AVS_WRITEDATA_I,
   input wire [3:0] AVS_BYTEENABLE_I,
   output reg [31:0] AVS_READDATA_O,
   output reg AVS_WAITREQUEST_O,
   input wire SAMPLE_CLOCK_I,
   input wire CLOCK_INPUT_INVERTED_I,
   input wire [SAMPLE_W-1:0] CONV_CODE_I,
   input wire CONV_UNDERFLOW_I,
   input wire CONV_OVERFLOW_I,
   input wire OUTPUT_FORMAT_SELECT_I,
   input wire CHIP_ENABLE_LOW_N_I,
   input wire SAMPLE_HOLD_CONTROL_I,
   input wire DONE_STROBE_SELECT_LO_I,
   input wire DONE_STROBE_SELECT_HI_I,
   output reg [SAMPLE_W-1:0] SAMPLE_WORD_O,
   output reg [SAMPLE_W-1:0] SAMPLE_WORD_OE_O,
   output reg IN_RANGE_FLAG_O,
   output reg IN_RANGE_FLAG_OE_O,
   output reg DONE_STROBE_O,
   output reg HOLD_ACTIVE_O,
   output reg IRQ_O
);
   localparam PIN_W = SAMPLE_W + 7;
   localparam [31:0] CTRL_RST = `ACX_CTRL_RESET;

   wire [1:0] clk_sync;
   wire [PIN_W-1:0] pin_sync;
   wire s_clk_true;
   wire s_clk_inv;
   wire [SAMPLE_W-1:0] s_code;
   wire s_under;
   wire s_over;
   wire s_fmt;
   wire s_ce_n;
   wire s_hold;
   wire [1:0] s_sel;

   reg clk_true_prev_r;
   reg clk_inv_prev_r;
   reg [2:0] mode_r;
   reg ac_inv_r;
   reg [`ACX_IRQ_W-1:0] irq_st_r;
   reg [`ACX_IRQ_W-1:0] irq_st_nxt;
   reg [`ACX_IRQ_W-1:0] irq_mask_r;
   reg [31:0] sample_cnt_r;
   reg [31:0] ctrl_nxt;
   reg [31:0] rd_mux;
   reg edge_hit;
   reg [SAMPLE_W-1:0] clamped;
   reg [SAMPLE_W-1:0] formatted;

   wire rise_true;
   wire fall_true;
   wire rise_inv;
   wire new_word;
   wire in_range;
   wire bus_req;
   wire bus_wr;
   wire [`ACX_IRQ_W-1:0] irq_set;
   wire [`ACX_IRQ_W-1:0] irq_clr;

   // the two clock pins go through their own pair so edges are seen on a coherent view
   acx_pin_sync #(
      .WIDTH(2)
   ) u_clk_sync (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .async_i({CLOCK_INPUT_INVERTED_I, SAMPLE_CLOCK_I}),
      .sync_o(clk_sync)
   );

   // multi-bit code is synchronised bitwise; the core must keep it steady near the edge
   acx_pin_sync #(
      .WIDTH(PIN_W)
   ) u_pin_sync (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .async_i({DONE_STROBE_SELECT_HI_I, DONE_STROBE_SELECT_LO_I, SAMPLE_HOLD_CONTROL_I,
                CHIP_ENABLE_LOW_N_I, OUTPUT_FORMAT_SELECT_I, CONV_OVERFLOW_I,
                CONV_UNDERFLOW_I, CONV_CODE_I}),
      .sync_o(pin_sync)
   );

   assign s_clk_true = clk_sync[0];
   assign s_clk_inv = clk_sync[1];
   assign s_code = pin_sync[SAMPLE_W-1:0];
   assign s_under = pin_sync[SAMPLE_W];
   assign s_over = pin_sync[SAMPLE_W+1];
   assign s_fmt = pin_sync[SAMPLE_W+2];
   assign s_ce_n = pin_sync[SAMPLE_W+3];
   assign s_hold = pin_sync[SAMPLE_W+4];
   assign s_sel = pin_sync[SAMPLE_W+6:SAMPLE_W+5];

   // edge detection on the synchronised clock pins
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         clk_true_prev_r <= 1'b0;
         clk_inv_prev_r <= 1'b0;
      end else begin
         clk_true_prev_r <= s_clk_true;
         clk_inv_prev_r <= s_clk_inv;
      end
   end

   assign rise_true = s_clk_true & ~clk_true_prev_r;
   assign fall_true = ~s_clk_true & clk_true_prev_r;
   assign rise_inv = s_clk_inv & ~clk_inv_prev_r;

   // sampling edge per clock input mode; unused codes give no edge, so they sample only in tracking mode
   always @* begin
      edge_hit = 1'b0;
      case (mode_r)
         `ACX_MODE_DIFF: begin
            edge_hit = rise_true;
         end
         `ACX_MODE_TRUE_SE: begin
            edge_hit = fall_true;
         end
         `ACX_MODE_INV_SE: begin
            edge_hit = rise_inv;
         end
         `ACX_MODE_AC: begin
            edge_hit = ac_inv_r ? rise_inv : fall_true;
         end
         `ACX_MODE_TTL: begin
            // inverted pin is grounded by the board, so only the true pin is watched
            edge_hit = fall_true;
         end
         default: begin
            edge_hit = 1'b0;
         end
      endcase
   end

   // tracking mode refreshes the word every core cycle
   assign new_word = s_hold ? edge_hit : 1'b1;

   // underflow takes priority if the core ever flags both
   always @* begin
      if (s_under) begin
         clamped = `ACX_CODE_LOW;
      end else if (s_over) begin
         clamped = `ACX_CODE_HIGH;
      end else begin
         clamped = s_code;
      end
      if (s_fmt) begin
         formatted = {~clamped[SAMPLE_W-1], clamped[SAMPLE_W-2:0]};
      end else begin
         formatted = clamped;
      end
   end

   assign in_range = ~(s_under | s_over);

   // output word, range flag, enables and strobe
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SAMPLE_WORD_O <= {SAMPLE_W{1'b0}};
         SAMPLE_WORD_OE_O <= {SAMPLE_W{1'b0}};
         IN_RANGE_FLAG_O <= 1'b0;
         IN_RANGE_FLAG_OE_O <= 1'b0;
         DONE_STROBE_O <= 1'b0;
         HOLD_ACTIVE_O <= 1'b0;
      end else begin
         if (new_word) begin
            SAMPLE_WORD_O <= formatted;
            IN_RANGE_FLAG_O <= in_range;
         end
         SAMPLE_WORD_OE_O <= {SAMPLE_W{~s_ce_n}};
         IN_RANGE_FLAG_OE_O <= ~s_ce_n;
         // selects 10 and 11 are left undefined; they are kept inactive here
         DONE_STROBE_O <= new_word & (s_sel == `ACX_STROBE_ON);
         HOLD_ACTIVE_O <= s_hold;
      end
   end

   // bus slave: one wait cycle, then the grant cycle with waitrequest low
   assign bus_req = AVS_READ_I | AVS_WRITE_I;
   assign bus_wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O;

   function [31:0] merge_bytes;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0] be;
      integer i;
      begin
         merge_bytes = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (be[i]) begin
               merge_bytes[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      rd_mux = 32'h0000_0000;
      case (AVS_ADDRESS_I)
         `ACX_OFF_CTRL: begin
            rd_mux[`ACX_CTRL_MODE_MSB:`ACX_CTRL_MODE_LSB] = mode_r;
            rd_mux[`ACX_CTRL_AC_INV_BIT] = ac_inv_r;
         end
         `ACX_OFF_STATUS: begin
            rd_mux[`ACX_ST_WORD_LSB +: SAMPLE_W] = SAMPLE_WORD_O;
            rd_mux[`ACX_ST_INRANGE_BIT] = IN_RANGE_FLAG_O;
            rd_mux[`ACX_ST_CE_LOW_BIT] = s_ce_n;
            rd_mux[`ACX_ST_FMT_BIT] = s_fmt;
            rd_mux[`ACX_ST_HOLD_BIT] = s_hold;
            rd_mux[`ACX_ST_SEL_LSB +: 2] = s_sel;
         end
         `ACX_OFF_IRQ_STATUS: begin
            rd_mux[`ACX_IRQ_W-1:0] = irq_st_r;
         end
         `ACX_OFF_IRQ_MASK: begin
            rd_mux[`ACX_IRQ_W-1:0] = irq_mask_r;
         end
         `ACX_OFF_SAMPLE_COUNT: begin
            rd_mux = sample_cnt_r;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always @* begin
      ctrl_nxt = merge_bytes({28'h0000000, ac_inv_r, mode_r}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
   end

   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         if (AVS_WAITREQUEST_O && bus_req) begin
            AVS_WAITREQUEST_O <= 1'b0;
            AVS_READDATA_O <= rd_mux;
         end else begin
            AVS_WAITREQUEST_O <= 1'b1;
         end
      end
   end

   // control and mask registers
   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_r <= CTRL_RST[`ACX_CTRL_MODE_MSB:`ACX_CTRL_MODE_LSB];
         ac_inv_r <= CTRL_RST[`ACX_CTRL_AC_INV_BIT];
         irq_mask_r <= `ACX_IRQ_MASK_RESET;
      end else if (bus_wr) begin
         if (AVS_ADDRESS_I == `ACX_OFF_CTRL) begin
            mode_r <= ctrl_nxt[`ACX_CTRL_MODE_MSB:`ACX_CTRL_MODE_LSB];
            ac_inv_r <= ctrl_nxt[`ACX_CTRL_AC_INV_BIT];
         end
         if (AVS_ADDRESS_I == `ACX_OFF_IRQ_MASK && AVS_BYTEENABLE_I[0]) begin
            irq_mask_r <= AVS_WRITEDATA_I[`ACX_IRQ_W-1:0];
         end
      end
   end

   // sticky events; a new event beats a write-one clear in the same cycle
   assign irq_set = {new_word & s_over, new_word & s_under, new_word};
   assign irq_clr = (bus_wr && AVS_ADDRESS_I == `ACX_OFF_IRQ_STATUS && AVS_BYTEENABLE_I[0]) ?
                    AVS_WRITEDATA_I[`ACX_IRQ_W-1:0] : {`ACX_IRQ_W{1'b0}};

   always @* begin
      irq_st_nxt = (irq_st_r & ~irq_clr) | irq_set;
   end

   always @(posedge CORE_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         irq_st_r <= {`ACX_IRQ_W{1'b0}};
         sample_cnt_r <= 32'h0000_0000;
         IRQ_O <= 1'b0;
      end else begin
         irq_st_r <= irq_st_nxt;
         IRQ_O <= |(irq_st_nxt & irq_mask_r);
         if (new_word) begin
            sample_cnt_r <= sample_cnt_r + 32'h0000_0001;
         end
      end
   end
endmodule

//--- testbench/acx_fmt_monitor.sv
// Purpose: port checker for the converter output control block
// Assumes: one core clock, asynchronous active-low reset
// Notes: pin rules allow for the two-flop input synchronisers
`timescale 1ns/10ps
module acx_fmt_monitor #(
   parameter SAMPLE_W = 12
) (
   input wire CORE_CLK_I,
   input wire RST_N_I,
   input wire AVS_READ_I,
   input wire AVS_WRITE_I,
   input wire AVS_WAITREQUEST_O,
   input wire SAMPLE_CLOCK_I,
   input wire CLOCK_INPUT_INVERTED_I,
   input wire CHIP_ENABLE_LOW_N_I,
   input wire SAMPLE_HOLD_CONTROL_I,
   input wire DONE_STROBE_SELECT_LO_I,
   input wire DONE_STROBE_SELECT_HI_I,
   input wire [SAMPLE_W-1:0] SAMPLE_WORD_O,
   input wire [SAMPLE_W-1:0] SAMPLE_WORD_OE_O,
   input wire IN_RANGE_FLAG_O,
   input wire IN_RANGE_FLAG_OE_O,
   input wire DONE_STROBE_O,
   input wire HOLD_ACTIVE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);
   wire sel_off = !DONE_STROBE_SELECT_LO_I || DONE_STROBE_SELECT_HI_I;
   sequence s_quiet;
      SAMPLE_HOLD_CONTROL_I && $stable(SAMPLE_CLOCK_I) && $stable(CLOCK_INPUT_INVERTED_I);
   endsequence
   property p_wait_one; !AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O; endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest low longer than one cycle");
   property p_grant; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
   a_grant: assert property (p_grant) else $error("request not granted in the next cycle");
   property p_oe_off; CHIP_ENABLE_LOW_N_I[*4] |-> SAMPLE_WORD_OE_O == '0 && !IN_RANGE_FLAG_OE_O; endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs driven while chip disabled");
   property p_oe_on; !CHIP_ENABLE_LOW_N_I[*4] |-> SAMPLE_WORD_OE_O == '1 && IN_RANGE_FLAG_OE_O; endproperty
   a_oe_on: assert property (p_oe_on) else $error("outputs not driven while chip enabled");
   property p_oe_same; SAMPLE_WORD_OE_O == {SAMPLE_W{IN_RANGE_FLAG_OE_O}}; endproperty
   a_oe_same: assert property (p_oe_same) else $error("word and flag enables differ");
   property p_sel_off; sel_off[*5] |-> !DONE_STROBE_O; endproperty
   a_sel_off: assert property (p_sel_off) else $error("done strobe with select not 01");
   property p_hold_on; SAMPLE_HOLD_CONTROL_I[*4] |-> HOLD_ACTIVE_O; endproperty
   a_hold_on: assert property (p_hold_on) else $error("hold not active");
   property p_hold_off; !SAMPLE_HOLD_CONTROL_I[*4] |-> !HOLD_ACTIVE_O; endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold active while tracking");
   property p_clamp; !IN_RANGE_FLAG_O |-> SAMPLE_WORD_O[10:0] == 11'h000 || SAMPLE_WORD_O[10:0] == 11'h7FF;
   endproperty
   a_clamp: assert property (p_clamp) else $error("out of range word not clamped");
   property p_no_edge; s_quiet[*7] |-> !DONE_STROBE_O; endproperty
   a_no_edge: assert property (p_no_edge) else $error("new word without sampling edge");
   c_under: cover property (DONE_STROBE_O && !IN_RANGE_FLAG_O);
   c_write: cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
   c_off: cover property ($fell(IN_RANGE_FLAG_OE_O));
endmodule

//--- testbench/acx_capture_model.sv
// Purpose: downstream capture logic for the sample word
// Assumes: strobe select 01, so every new word comes with a strobe
// Notes: counts only words seen while the outputs are driven
`timescale 1ns/10ps
module acx_capture_model (
   input wire clk_i,
   input wire rst_n_i,
   input wire strobe_i,
   input wire oe_i,
   input wire [11:0] word_i,
   input wire flag_i,
   output logic [11:0] last_word_o,
   output logic last_flag_o,
   output int count_o
);
   // strobe and word are updated on the same core edge, so the word is already valid when the strobe is seen
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         last_word_o <= 12'h000;
         last_flag_o <= 1'b0;
         count_o <= 0;
      end else if (strobe_i && oe_i) begin
         last_word_o <= word_i;
         last_flag_o <= flag_i;
         count_o <= count_o + 1;
      end
   end
endmodule

//--- testbench/test_adc_output_format_control.sv
// Purpose: register and sample path tests of the output control block
// Assumes: pins move slowly against the 200 MHz core clock
// Notes: latency is not assumed; each pin edge gets eight core cycles, a chip enable edge six
`timescale 1ns/10ps
module test_adc_output_format_control;
   logic clk = 0, rst_n = 0, rd = 0, wr = 0, tclk = 0, iclk = 0, under = 0, over = 0;
   logic fmt = 0, ce_n = 0, hold = 1, slo = 1, shi = 0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0, rdata, q, q0;
   logic [11:0] code = 12'h000, word, oe, cw;
   logic wreq, flag, flag_oe, strobe, hold_o, irq, cf;
   int failures = 0, cmp_count = 0, cc;
   logic [27:0] st [7] = '{{12'h123, 3'b000, 12'h123, 1'b1}, {12'h123, 3'b001, 12'h923, 1'b1},
      {12'h5A5, 3'b100, 12'h000, 1'b0}, {12'h5A5, 3'b010, 12'hFFF, 1'b0}, {12'h5A5, 3'b101, 12'h800, 1'b0},
      {12'h5A5, 3'b011, 12'h7FF, 1'b0}, {12'hFFF, 3'b001, 12'h7FF, 1'b1}};
   // {ctrl[3:0], true pin, final level, strobes expected}; each pin is first set to the opposite level
   logic [6:0] md [8] = '{7'h0F, 7'h15, 7'h1B, 7'h25, 7'h63, 7'h64, 7'h34, 7'h02};
   always #2.5 clk = ~clk;
   acx_format_ctrl acx_format_ctrl_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq), .SAMPLE_CLOCK_I(tclk), .CLOCK_INPUT_INVERTED_I(iclk),
      .CONV_CODE_I(code), .CONV_UNDERFLOW_I(under), .CONV_OVERFLOW_I(over), .OUTPUT_FORMAT_SELECT_I(fmt),
      .CHIP_ENABLE_LOW_N_I(ce_n), .SAMPLE_HOLD_CONTROL_I(hold), .DONE_STROBE_SELECT_LO_I(slo),
      .DONE_STROBE_SELECT_HI_I(shi), .SAMPLE_WORD_O(word), .SAMPLE_WORD_OE_O(oe), .IN_RANGE_FLAG_O(flag),
      .IN_RANGE_FLAG_OE_O(flag_oe), .DONE_STROBE_O(strobe), .HOLD_ACTIVE_O(hold_o), .IRQ_O(irq));
   acx_capture_model acx_capture_model_inst (.clk_i(clk), .rst_n_i(rst_n), .strobe_i(strobe),
      .oe_i(flag_oe), .word_i(word), .flag_i(flag), .last_word_o(cw), .last_flag_o(cf), .count_o(cc));
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask
   // request held until waitrequest is seen low at an edge
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      // no cycle count is assumed; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      r = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task pin(input logic t, input logic v, input int exp);
      int n0;
      n0 = cc;
      @(posedge clk);
      if (t)
         tclk <= v;
      else
         iclk <= v;
      repeat (8) @(posedge clk);
      chk_reg(cc - n0, exp);
   endtask
   task smp(input logic [27:0] s);
      @(posedge clk);
      {code, under, over, fmt} <= s[27:13];
      pin(1'b1, 1'b1, 0);
      pin(1'b1, 1'b0, 1);
      chk_reg({20'h0, cw}, {20'h0, s[12:1]});
      chk_bit(cf, s[0]);
   endtask
   initial begin
      #100000;
      failures++;
      conclude;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      bus(0, 5'h00, 0, q);
      chk_reg(q, 32'h5);
      bus(1, 5'h14, 32'hFFFF_FFFF, q);
      bus(0, 5'h14, 0, q);
      chk_reg(q, 32'h0);
      bus(0, 5'h0C, 0, q);
      chk_reg(q, 32'h0);
      $display("registers done");
      foreach (st[i]) smp(st[i]);
      $display("coding done");
      foreach (md[i]) begin
         bus(1, 5'h00, {28'h0, md[i][6:3]}, q);
         pin(md[i][2], !md[i][1], 0);
         pin(md[i][2], md[i][1], {31'h0, md[i][0]});
      end
      // inverted input grounded again for the TTL mode
      iclk <= 1'b0;
      bus(1, 5'h00, 32'h5, q);
      $display("clock modes done");
      for (int s = 0; s < 3; s++) begin
         {shi, slo} <= {1'b0, s[0]};
         pin(1'b1, 1'b1, 0);
         pin(1'b1, 1'b0, s[0]);
      end
      {shi, slo} <= 2'b01;
      $display("strobe select done");
      ce_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk_reg({20'h0, oe}, 32'h0);
      chk_bit(flag_oe, 1'b0);
      ce_n <= 1'b0;
      repeat (6) @(posedge clk);
      chk_reg({20'h0, oe}, 32'hFFF);
      hold <= 1'b0;
      code <= 12'h3C3;
      {under, over, fmt} <= 3'b000;
      repeat (8) @(posedge clk);
      chk_bit(hold_o, 1'b0);
      chk_reg({20'h0, word}, 32'h3C3);
      hold <= 1'b1;
      repeat (8) @(posedge clk);
      chk_bit(hold_o, 1'b1);
      $display("enable and hold done");
      bus(1, 5'h08, 32'h7, q);
      bus(1, 5'h0C, 32'h2, q);
      smp({12'h123, 3'b100, 12'h000, 1'b0});
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'b1);
      bus(0, 5'h08, 0, q);
      chk_reg(q, 32'h3);
      bus(1, 5'h08, 32'h7, q);
      repeat (2) @(posedge clk);
      chk_bit(irq, 1'b0);
      bus(0, 5'h10, 0, q0);
      smp({12'h123, 3'b000, 12'h123, 1'b1});
      chk_bit(irq, 1'b0);
      bus(0, 5'h10, 0, q);
      chk_reg(q, q0 + 32'h1);
      bus(0, 5'h04, 0, q);
      chk_reg(q, 32'h0001_9123);
      $display("interrupts done");
      conclude;
   end
endmodule
bind acx_format_ctrl acx_fmt_monitor #(.SAMPLE_W(SAMPLE_W)) acx_fmt_monitor_inst (.CORE_CLK_I(CORE_CLK_I),
   .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
   .SAMPLE_CLOCK_I(SAMPLE_CLOCK_I), .CLOCK_INPUT_INVERTED_I(CLOCK_INPUT_INVERTED_I),
   .CHIP_ENABLE_LOW_N_I(CHIP_ENABLE_LOW_N_I), .SAMPLE_HOLD_CONTROL_I(SAMPLE_HOLD_CONTROL_I),
   .DONE_STROBE_SELECT_LO_I(DONE_STROBE_SELECT_LO_I), .DONE_STROBE_SELECT_HI_I(DONE_STROBE_SELECT_HI_I),
   .SAMPLE_WORD_O(SAMPLE_WORD_O), .SAMPLE_WORD_OE_O(SAMPLE_WORD_OE_O), .IN_RANGE_FLAG_O(IN_RANGE_FLAG_O),
   .IN_RANGE_FLAG_OE_O(IN_RANGE_FLAG_OE_O), .DONE_STROBE_O(DONE_STROBE_O), .HOLD_ACTIVE_O(HOLD_ACTIVE_O));
